// ==== include/cls_cfg.svh ====
/*
 Constants of the counter, latch and byte scanner: widths, pin group
 layouts, idle levels and the timing counts at the system clock rate.
 Assumes it is included by bare name from the package and the modules.
*/
`ifndef CLS_CFG_SVH
`define CLS_CFG_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define CLS_CLK_MHZ        100
`define CLS_MIN_LOW_NS     1000
`define CLS_MIN_LOW_CYC    ((`CLS_MIN_LOW_NS*`CLS_CLK_MHZ+999)/1000)
`define CLS_FAST_HOLD      1

// ****************************************************************
// Widths and layout
// ****************************************************************
`define CLS_CNT_W          32
`define CLS_PRE_W          8
`define CLS_PRE_LOW_W      7
`define CLS_SNAP_W         40
`define CLS_BYTE_W         8
`define CLS_NUM_BYTES      5
`define CLS_PTR_W          6
`define CLS_FIFO_DEPTH     32
`define CLS_TEST_GATE_BIT  15
`define CLS_UPPER_LSB      16
`define CLS_CNT_RST        32'h0000_0000
`define CLS_SNAP_RST       40'h00_0000_0000
`define CLS_BYTE_RST       8'h00

// ****************************************************************
// Slow pin group: qualified for the minimum low time
// ****************************************************************
`define CLS_SLOW_W         4
`define CLS_SLOW_IDLE      4'hf
`define CLS_S_CNT_RST      0
`define CLS_S_LOAD         1
`define CLS_S_RESTART      2
`define CLS_S_RESCAP       3

// ****************************************************************
// Fast pin group: synchronised only
// ****************************************************************
`define CLS_FAST_W         11
`define CLS_FAST_IDLE      11'h680
`define CLS_F_COUNT        10
`define CLS_F_TEST         9
`define CLS_F_SCAN         8
`define CLS_F_ENABLE       7

`endif

// ==== include/cls_pkg.sv ====
/*
 Types of the counter, latch and byte scanner.
 Assumes cls_cfg.svh is on the include path.
*/
`include "cls_cfg.svh"

package cls_pkg;

   // ****************************************************************
   // Byte pointer states, one-hot
   // ****************************************************************
   typedef enum logic [`CLS_PTR_W-1:0] {
      CLS_ST1 = 6'h01,
      CLS_ST2 = 6'h02,
      CLS_ST3 = 6'h04,
      CLS_ST4 = 6'h08,
      CLS_ST5 = 6'h10,
      CLS_ST6 = 6'h20
   } cls_ptr_e;

   typedef logic [`CLS_SNAP_W-1:0] cls_snap_t;
   typedef logic [`CLS_BYTE_W-1:0] cls_byte_t;

endpackage : cls_pkg

// ==== include/cls_stream_if.sv ====
/*
 Valid/ready stream carrier between the scanner and its snapshot FIFO.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface cls_stream_if #(parameter int WIDTH = 8) ();
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : cls_stream_if

`default_nettype wire

// ==== src/cls_sync_qual.sv ====
/*
 Two-flop synchroniser for a group of pins, with a per-bit detector
 that flags a level held low for HOLD consecutive clocks.
 Assumes pins are asynchronous to i_clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module cls_sync_qual #(
   parameter int           W    = 1,
   parameter int           HOLD = 1,
   parameter logic [W-1:0] IDLE = '1
) (
   // Clock and reset
   input  wire logic         i_clk_sys,
   input  wire logic         i_reset_n,
   // Pins and results
   input  wire logic [W-1:0] i_pin,
   output logic      [W-1:0] o_level,
   output logic      [W-1:0] o_held_low
);

   localparam int CW = $clog2(HOLD + 1);

   logic [W-1:0] meta_q;

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta_q  <= IDLE;
         o_level <= IDLE;
      end else begin
         meta_q  <= i_pin;
         o_level <= meta_q;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_bit
         logic [CW-1:0] cnt_q;
         always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
            if (!i_reset_n) begin
               cnt_q <= '0;
            end else if (o_level[gi]) begin
               cnt_q <= '0;
            end else if (cnt_q != CW'(HOLD)) begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
         assign o_held_low[gi] = (cnt_q == CW'(HOLD));
      end
   endgenerate

endmodule : cls_sync_qual

`default_nettype wire

// ==== src/cls_fifo.sv ====
/*
 Snapshot FIFO with parameterised width and depth, valid/ready both sides.
 Assumes DEPTH is a power of two and interface widths equal WIDTH.
*/
`timescale 1ns/1ps
`default_nettype none

module cls_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_reset_n,
   // Streams
   cls_stream_if.snk s_in,
   cls_stream_if.src s_out
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wptr_q;
   logic [AW:0]      rptr_q;
   logic             full;
   logic             empty;

   assign empty = (wptr_q == rptr_q);
   assign full  = (wptr_q[AW] != rptr_q[AW]) &&
                  (wptr_q[AW-1:0] == rptr_q[AW-1:0]);

   assign s_in.ready  = !full;
   assign s_out.valid = !empty;
   assign s_out.data  = mem[rptr_q[AW-1:0]];

   always_ff @(posedge i_clk_sys) begin
      if (s_in.valid && !full) begin
         mem[wptr_q[AW-1:0]] <= s_in.data;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wptr_q <= '0;
      end else if (s_in.valid && !full) begin
         wptr_q <= wptr_q + 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rptr_q <= '0;
      end else if (s_out.ready && !empty) begin
         rptr_q <= rptr_q + 1'b1;
      end
   end

endmodule : cls_fifo

`default_nettype wire

// ==== src/cls_counter_latch_scanner.sv ====
/*
 32-bit up counter with 40-bit holding latch and byte scanner that puts
 the latched value on an 8-bit three-state bus, one byte per strobe,
 with a chain output for several devices sharing one bus.
 Assumes all pins are asynchronous to i_clk_sys and are far slower than
 it; the bus wire level is resolved outside from o_data_oe.
*/
// Notes on behaviour
// - 32-bit counter increments on count falling edge.
// - Count pin also prescaler byte's top bit.
// - Counter reset low one microsecond clears counter.
// - Test count advances upper half while bit16 low.
// - Forty latch bits: prescaler byte plus counter.
// - Restart low one microsecond sets pointer state1.
// - Pointer advances on strobe fall while enabled.
// - State6 disables drivers, holds until restart.
// - Strobe low floats bus; high drives byte.
// - Restart-capture resets pointer and loads latches.
// - Enable high freezes pointer and floats bus.
// - Chain output rests high, low when finished.
// - Chain output feeds next device's enable.
`timescale 1ns/1ps
`default_nettype none

`include "cls_cfg.svh"

module cls_counter_latch_scanner
   import cls_pkg::*;
(
   // Clock and reset
   input  wire logic                      i_clk_sys,
   input  wire logic                      i_reset_n,
   // Count and prescaler pins
   input  wire logic                      i_count_clock_msb_input,
   input  wire logic [`CLS_PRE_LOW_W-1:0] i_byte_bus_lines,
   input  wire logic                      i_test_count_n,
   input  wire logic                      i_counter_reset_n,
   // Latch and scan control pins
   input  wire logic                      i_load_n,
   input  wire logic                      i_scan_restart_n,
   input  wire logic                      i_restart_capture_n,
   input  wire logic                      i_scan,
   input  wire logic                      i_enable_n,
   // Data bus and chain
   output logic      [`CLS_BYTE_W-1:0]    o_data,
   output logic                           o_data_oe,
   output logic                           o_chain_pass
);

   // ****************************************************************
   // Local constants
   // ****************************************************************
   localparam logic [`CLS_FAST_W-1:0] FAST_IDLE = `CLS_FAST_IDLE;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [`CLS_SLOW_W-1:0]    slow_pin;
   logic [`CLS_SLOW_W-1:0]    slow_lvl;
   logic [`CLS_SLOW_W-1:0]    slow_held;
   logic [`CLS_FAST_W-1:0]    fast_pin;
   logic [`CLS_FAST_W-1:0]    fast_lvl;

   assign slow_pin = {i_restart_capture_n, i_scan_restart_n,
                      i_load_n, i_counter_reset_n};
   assign fast_pin = {i_count_clock_msb_input, i_test_count_n,
                      i_scan, i_enable_n, i_byte_bus_lines};

   // Minimum low time qualifies the slow controls
   cls_sync_qual #(
      .W    (`CLS_SLOW_W),
      .HOLD (`CLS_MIN_LOW_CYC),
      .IDLE (`CLS_SLOW_IDLE)
   ) u_slow (
      .i_clk_sys  (i_clk_sys),
      .i_reset_n  (i_reset_n),
      .i_pin      (slow_pin),
      .o_level    (slow_lvl),
      .o_held_low (slow_held)
   );

   // Fast pins are only synchronised; edges show two clocks late
   cls_sync_qual #(
      .W    (`CLS_FAST_W),
      .HOLD (`CLS_FAST_HOLD),
      .IDLE (`CLS_FAST_IDLE)
   ) u_fast (
      .i_clk_sys  (i_clk_sys),
      .i_reset_n  (i_reset_n),
      .i_pin      (fast_pin),
      .o_level    (fast_lvl),
      .o_held_low ()
   );

   // ****************************************************************
   // Edge detection
   // ****************************************************************
   logic       count_prev_q;
   logic       test_prev_q;
   logic       scan_prev_q;
   logic       count_fall;
   logic       test_fall;
   logic       scan_fall;
   logic       scan_lvl;
   logic       enable_n_lvl;
   logic       cnt_clear;
   logic       load_low;
   logic       restart_low;
   logic       rescap_low;

   // Previous levels start at each pin's idle level: no false edge
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         count_prev_q <= FAST_IDLE[`CLS_F_COUNT];
      end else begin
         count_prev_q <= fast_lvl[`CLS_F_COUNT];
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         test_prev_q <= FAST_IDLE[`CLS_F_TEST];
      end else begin
         test_prev_q <= fast_lvl[`CLS_F_TEST];
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         scan_prev_q <= FAST_IDLE[`CLS_F_SCAN];
      end else begin
         scan_prev_q <= fast_lvl[`CLS_F_SCAN];
      end
   end

   assign count_fall   = count_prev_q && !fast_lvl[`CLS_F_COUNT];
   assign test_fall    = test_prev_q && !fast_lvl[`CLS_F_TEST];
   assign scan_fall    = scan_prev_q && !fast_lvl[`CLS_F_SCAN];
   assign scan_lvl     = fast_lvl[`CLS_F_SCAN];
   assign enable_n_lvl = fast_lvl[`CLS_F_ENABLE];
   assign cnt_clear    = slow_held[`CLS_S_CNT_RST];
   assign load_low     = slow_held[`CLS_S_LOAD];
   assign restart_low  = slow_held[`CLS_S_RESTART];
   assign rescap_low   = slow_held[`CLS_S_RESCAP];

   // ****************************************************************
   // Binary counter
   // ****************************************************************
   logic [`CLS_CNT_W-1:0] cnt_q;
   logic [`CLS_CNT_W-1:0] cnt_inc;
   logic                  upper_step;

   // Upper half steps only while the gate bit is clear
   // Gate is the sixteenth bit, counted from one
   assign upper_step = test_fall && !cnt_q[`CLS_TEST_GATE_BIT];
   assign cnt_inc    = ({31'h0000_0000, upper_step} << `CLS_UPPER_LSB) |
                       {31'h0000_0000, count_fall};

   // Clear outranks a count edge in the same cycle
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_q <= `CLS_CNT_RST;
      end else if (cnt_clear) begin
         cnt_q <= `CLS_CNT_RST;
      end else begin
         cnt_q <= cnt_q + cnt_inc;
      end
   end

   // ****************************************************************
   // Capture latch
   // ****************************************************************
   cls_snap_t  snap_q;
   logic       cap_low_q;
   logic       cap_low;
   logic       pend_q;
   logic [`CLS_PRE_W-1:0] pre_byte;

   // Count pin doubles as top prescaler bit
   assign pre_byte = {fast_lvl[`CLS_F_COUNT],
                      fast_lvl[`CLS_PRE_LOW_W-1:0]};
   assign cap_low  = load_low || rescap_low;

   // Transparent while the capture input is held low
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         snap_q <= `CLS_SNAP_RST;
      end else if (cap_low) begin
         snap_q <= {cnt_q, pre_byte};
      end
   end

   // Delayed capture level, to find its release
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cap_low_q <= 1'b0;
      end else begin
         cap_low_q <= cap_low;
      end
   end

   cls_stream_if #(.WIDTH(`CLS_SNAP_W)) fifo_in ();
   cls_stream_if #(.WIDTH(`CLS_SNAP_W)) fifo_out ();

   // Release stores the value; held until the FIFO accepts it
   // A new release wins over the FIFO taking the older word
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pend_q <= 1'b0;
      end else if (cap_low_q && !cap_low) begin
         pend_q <= 1'b1;
      end else if (fifo_in.ready) begin
         pend_q <= 1'b0;
      end
   end

   assign fifo_in.valid = pend_q;
   assign fifo_in.data  = snap_q;

   // Depth absorbs captures taken while a readout runs
   cls_fifo #(
      .WIDTH (`CLS_SNAP_W),
      .DEPTH (`CLS_FIFO_DEPTH)
   ) u_fifo (
      .i_clk_sys (i_clk_sys),
      .i_reset_n (i_reset_n),
      .s_in      (fifo_in),
      .s_out     (fifo_out)
   );

   // ****************************************************************
   // Byte pointer
   // ****************************************************************
   cls_ptr_e ptr_q;
   cls_ptr_e ptr_d;

   always_comb begin
      case (ptr_q)
         CLS_ST1: ptr_d = CLS_ST2;
         CLS_ST2: ptr_d = CLS_ST3;
         CLS_ST3: ptr_d = CLS_ST4;
         CLS_ST4: ptr_d = CLS_ST5;
         CLS_ST5: ptr_d = CLS_ST6;
         CLS_ST6: ptr_d = CLS_ST6;
         default: ptr_d = CLS_ST1;
      endcase
   end

   // Restart outranks a strobe edge in the same cycle
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ptr_q <= CLS_ST1;
      end else if (restart_low || rescap_low) begin
         ptr_q <= CLS_ST1;
      end else if (scan_fall && !enable_n_lvl) begin
         ptr_q <= ptr_d;
      end
   end

   // ****************************************************************
   // Output latch, fed from the FIFO between readouts
   // ****************************************************************
   cls_snap_t  latch_q;
   logic       drain_ok;

   // A new value can tear a readout in progress only in the cycle of the first strobe fall, while state1 still allows a load
   assign drain_ok = !scan_lvl && ((ptr_q == CLS_ST1) ||
                                   (ptr_q == CLS_ST6));
   assign fifo_out.ready = drain_ok;

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         latch_q <= `CLS_SNAP_RST;
      end else if (fifo_out.valid && drain_ok) begin
         latch_q <= fifo_out.data;
      end
   end

   // ****************************************************************
   // Byte select
   // ****************************************************************
   cls_byte_t  part [`CLS_NUM_BYTES];
   cls_byte_t  sel_byte;

   // One-hot pointer: OR of gated bytes, no priority chain
   genvar gi;
   generate
      for (gi = 0; gi < `CLS_NUM_BYTES; gi++) begin : g_byte
         assign part[gi] = ptr_q[gi] ?
            latch_q[gi*`CLS_BYTE_W +: `CLS_BYTE_W] : `CLS_BYTE_RST;
      end
   endgenerate

   always_comb begin
      sel_byte = `CLS_BYTE_RST;
      for (int i = 0; i < `CLS_NUM_BYTES; i++) begin
         sel_byte = sel_byte | part[i];
      end
   end

   // ****************************************************************
   // Data bus drivers and chain output
   // ****************************************************************
   logic       drive;

   // Drivers follow the synchronised strobe, three clocks behind the pin
   assign drive = scan_lvl && !enable_n_lvl &&
                  (ptr_q != CLS_ST6);

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_data_oe <= 1'b0;
      end else begin
         o_data_oe <= drive;
      end
   end

   // Bus value is zero while released
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_data <= `CLS_BYTE_RST;
      end else begin
         o_data <= drive ? sel_byte : `CLS_BYTE_RST;
      end
   end

   // Low once finished; restart lifts it for the next device
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_chain_pass <= 1'b1;
      end else begin
         o_chain_pass <= (ptr_q != CLS_ST6);
      end
   end

endmodule : cls_counter_latch_scanner

`default_nettype wire

// ==== verification/cls_monitor.sv ====
/*
 Concurrent checks on the scanner's bus and chain pins.
 Assumes it is bound to cls_counter_latch_scanner.
*/
`timescale 1ns/1ps
`default_nettype none

module cls_monitor (
   // Clock and reset
   input wire logic       i_clk_sys,
   input wire logic       i_reset_n,
   // Control pins
   input wire logic       i_scan,
   input wire logic       i_enable_n,
   input wire logic       i_restart_capture_n,
   // Bus and chain
   input wire logic [7:0] o_data,
   input wire logic       o_data_oe,
   input wire logic       o_chain_pass
);
   logic [7:0] low_cnt_q;

   // Consecutive cycles of restart-capture low
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         low_cnt_q <= 8'h00;
      end else if (i_restart_capture_n) begin
         low_cnt_q <= 8'h00;
      end else if (low_cnt_q != 8'hff) begin
         low_cnt_q <= low_cnt_q + 8'h01;
      end
   end

   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);

   sequence s_scan_low;
      !i_scan [*4];
   endsequence
   sequence s_disabled;
      i_enable_n [*4];
   endsequence

   property p_float_scan;
      s_scan_low |-> !o_data_oe;
   endproperty
   a_float_scan: assert property (p_float_scan)
      else $error("bus driven while scan low");
   property p_float_off;
      s_disabled |-> !o_data_oe;
   endproperty
   a_float_off: assert property (p_float_off)
      else $error("bus driven while disabled");
   property p_chain_off;
      !o_chain_pass |-> !o_data_oe;
   endproperty
   a_chain_off: assert property (p_chain_off)
      else $error("bus driven in final state");
   property p_chain_back;
      (low_cnt_q >= 8'h6a) |-> o_chain_pass;
   endproperty
   a_chain_back: assert property (p_chain_back)
      else $error("chain low after restart capture");
   property p_chain_fall;
      $fell(o_chain_pass) |->
         !$past(i_scan) && !$past(i_scan, 2) && !$past(i_enable_n, 3);
   endproperty
   a_chain_fall: assert property (p_chain_fall)
      else $error("chain fell without scan fall");
   property p_oe_rise;
      $rose(o_data_oe) |->
         $past(i_scan, 2) && !$past(i_enable_n, 2) && o_chain_pass;
   endproperty
   a_oe_rise: assert property (p_oe_rise)
      else $error("bus enabled without scan high");
   property p_oe_fall;
      $fell(o_data_oe) |-> !$past(i_scan, 2) || $past(i_enable_n, 2);
   endproperty
   a_oe_fall: assert property (p_oe_fall)
      else $error("bus released without cause");
   property p_hold_byte;
      o_data_oe && $past(o_data_oe) |-> $stable(o_data);
   endproperty
   a_hold_byte: assert property (p_hold_byte)
      else $error("byte changed while driven");
endmodule : cls_monitor

bind cls_counter_latch_scanner cls_monitor u_mon (
   .i_clk_sys           (i_clk_sys),
   .i_reset_n           (i_reset_n),
   .i_scan              (i_scan),
   .i_enable_n          (i_enable_n),
   .i_restart_capture_n (i_restart_capture_n),
   .o_data              (o_data),
   .o_data_oe           (o_data_oe),
   .o_chain_pass        (o_chain_pass)
);

`default_nettype wire

// ==== verification/cls_host_model.sv ====
/*
 Host that restarts the scanner (mode 1 restart, mode 2 restart-capture, other modes neither) and reads six byte slots.
 Assumes a 100 MHz clock; reports {enable, bus} per high phase.
*/
`timescale 1ns/1ps
`default_nettype none

module cls_host_model (
   input  wire logic       i_clk_sys,
   input  wire logic       i_go,
   input  wire logic [1:0] i_mode,
   input  wire logic [7:0] i_bus,
   input  wire logic       i_bus_oe,
   output logic            o_scan,
   output logic            o_restart_n,
   output logic            o_rescap_n,
   output logic            o_rd_valid,
   output logic [8:0]      o_rd,
   output logic            o_busy
);
   initial begin
      o_scan = 1'b0;
      o_restart_n = 1'b1;
      o_rescap_n = 1'b1;
      o_rd_valid = 1'b0;
      o_rd = 9'h000;
      o_busy = 1'b0;
      forever begin
         @(posedge i_clk_sys);
         if (i_go) begin
            o_busy <= 1'b1;
            o_restart_n <= (i_mode != 2'h1);
            o_rescap_n <= (i_mode != 2'h2);
            repeat (420) @(posedge i_clk_sys);
            o_restart_n <= 1'b1;
            o_rescap_n <= 1'b1;
            repeat (30) @(posedge i_clk_sys);
            for (int i = 0; i < 6; i++) begin
               o_scan <= 1'b1;
               repeat (60) @(posedge i_clk_sys);
               o_rd_valid <= 1'b1;
               o_rd <= {i_bus_oe, i_bus};
               o_scan <= 1'b0;
               @(posedge i_clk_sys);
               o_rd_valid <= 1'b0;
               repeat (59) @(posedge i_clk_sys);
            end
            o_busy <= 1'b0;
         end
      end
   end
endmodule : cls_host_model

`default_nettype wire

// ==== verification/tb.sv ====
/*
 Self-checking bench of the counter, latch and byte scanner.
 Assumes the host model and the bound monitor are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cnt_pin = 1'b1;
   logic [6:0]  lines = 7'h00;
   logic        test_n = 1'b1;
   logic        crst_n = 1'b1;
   logic        load_n = 1'b1;
   logic        en_n = 1'b0;
   logic        go = 1'b0;
   logic [1:0]  mode = 2'h0;
   logic [7:0]  last_q = 8'h00;
   logic [7:0]  exp_last = 8'h00;
   logic [31:0] cnt_exp = 32'h0;
   logic [31:0] rng = 32'h4;
   logic [8:0]  exp_q[$];
   int          mismatches = 0;
   int          n_tests = 0;
   wire  [7:0]  data;
   wire  [7:0]  bus;
   wire  [8:0]  rd;
   wire         oe, chain, scan, rs_n, rc_n, rd_valid, busy;

   always #5 clk = ~clk;

   // Released bus shows the inverse of the last driven byte
   assign bus = oe ? data : ~last_q;
   always @(posedge clk) if (oe) last_q <= data;

   cls_counter_latch_scanner dut (
      .i_clk_sys               (clk),
      .i_reset_n               (rst_n),
      .i_count_clock_msb_input (cnt_pin),
      .i_byte_bus_lines        (lines),
      .i_test_count_n          (test_n),
      .i_counter_reset_n       (crst_n),
      .i_load_n                (load_n),
      .i_scan_restart_n        (rs_n),
      .i_restart_capture_n     (rc_n),
      .i_scan                  (scan),
      .i_enable_n              (en_n),
      .o_data                  (data),
      .o_data_oe               (oe),
      .o_chain_pass            (chain)
   );

   cls_host_model host (
      .i_clk_sys   (clk),
      .i_go        (go),
      .i_mode      (mode),
      .i_bus       (bus),
      .i_bus_oe    (oe),
      .o_scan      (scan),
      .o_restart_n (rs_n),
      .o_rescap_n  (rc_n),
      .o_rd_valid  (rd_valid),
      .o_rd        (rd),
      .o_busy      (busy)
   );

   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : rnd

   task automatic test_done();
      if (mismatches == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask : wait_clk

   // Falling edges on the count pin or on the test pin
   task automatic pulse(input int n, input logic tst);
      repeat (n) begin
         cnt_pin <= tst;
         test_n <= ~tst;
         wait_clk(3);
         cnt_pin <= 1'b1;
         test_n <= 1'b1;
         wait_clk(3);
         cnt_exp = cnt_exp + (tst ? 32'h0001_0000 : 32'h1);
      end
   endtask : pulse

   task automatic expect_read(input logic [39:0] snap);
      for (int i = 0; i < 5; i++)
         exp_q.push_back({1'b1, snap[8*i +: 8]});
      exp_last = snap[39:32];
      exp_q.push_back({1'b0, ~exp_last});
   endtask : expect_read

   task automatic expect_float();
      repeat (6) exp_q.push_back({1'b0, ~exp_last});
   endtask : expect_float

   task automatic readout(input logic [1:0] m);
      int n;
      go <= 1'b1;
      mode <= m;
      wait_clk(1);
      go <= 1'b0;
      wait_clk(1);
      n = 0;
      while (busy && n < 2000) begin
         wait_clk(1);
         n++;
      end
      if (busy) begin
         mismatches++;
         $display("BAD t=%0t busy=%h exp=%h", $time, busy, 1'b0);
         test_done();
      end
   endtask : readout

   // Byte watcher
   always @(posedge clk) begin
      if (rd_valid) begin
         check(rd, exp_q.size() != 0 ? exp_q.pop_front() : 'x);
      end
   end

   initial begin
      logic [39:0] snap;
      logic [31:0] r;
      wait_clk(8);
      rst_n <= 1'b1;
      wait_clk(40);
      for (int k = 0; k < 3; k++) begin
         r = rnd();
         lines <= r[6:0];
         pulse(int'(r[12:8]) + 1, 1'b0);
         expect_read({cnt_exp, 1'b1, r[6:0]});
         readout(2'h2);
      end
      pulse(3, 1'b1);
      cnt_pin <= 1'b0;
      cnt_exp = cnt_exp + 32'h1;
      wait_clk(10);
      expect_read({cnt_exp, 1'b0, lines});
      readout(2'h2);
      check({8'h00, chain}, 9'h000);
      cnt_pin <= 1'b1;
      crst_n <= 1'b0;
      wait_clk(120);
      crst_n <= 1'b1;
      cnt_exp = 32'h0;
      wait_clk(40);
      pulse(5, 1'b0);
      crst_n <= 1'b0;
      wait_clk(50);
      crst_n <= 1'b1;
      wait_clk(40);
      load_n <= 1'b0;
      wait_clk(420);
      load_n <= 1'b1;
      wait_clk(30);
      snap = {cnt_exp, 1'b1, lines};
      expect_read(snap);
      readout(2'h1);
      en_n <= 1'b1;
      expect_float();
      readout(2'h1);
      en_n <= 1'b0;
      expect_read(snap);
      readout(2'h0);
      expect_float();
      readout(2'h0);
      if (exp_q.size() != 0) begin
         mismatches++;
         $display("BAD t=%0t left=%h exp=%h", $time, exp_q.size(), 0);
      end
      test_done();
   end
endmodule : tb

`default_nettype wire
